/* File: logic/space_tag.sv */
// bus cycle space tagging, cpu-space address forming and vector fetch addressing
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// (R1) every cycle carries a three-bit space code
// (R2) code 3 user-defined; 0 and 4 generated only by alternate move
// (R3) reset fetches two long words at zero
// (R4) cpu-space type field on A19..A16
// (R5) far cpu-space decoders ignore A31..A20
// (R6) reserved types 0001, 0010 never issued
// (R7) breakpoint number on A4..A2, hardware gives 7
// (R8) A1 low software, high hardware breakpoint
// (R9) other breakpoint address bits zero, A0 too
// (R10) stop broadcast writes mask level on A3..A1
// (R11) bus interface blocks lower interrupts while stopped; here the far end only stores the level on mask_level_o
// (R12) chip, module, register select on A15..A0
// (R13) type 0011 reached by stop broadcast and alternate move
// (R14) supervisor alternate alternate_space_move reach every space
// (R15) interrupt acknowledge: ones above, level A3..A1
// (R16) vector table base locates 256-vector table
// (R17) vector address is base plus number times four
// (R18) vector fetch supervisor data, reset supervisor program
// (R19) reset vector is stack pointer then pc
// (R20) vector number internal or from external device
// (R21) acknowledges and stop broadcast use cpu space
// (R22) supervisor bit selects supervisor or user codes
// (R23) exception processing always uses supervisor codes
module space_tag #(
   parameter logic [3:0] MASK_CHIP_SEL = 4'h0,
   parameter logic [3:0] MASK_MODULE_SEL = 4'h0,
   parameter logic [3:0] MASK_REG_HI = 4'h0
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire space_tag_pkg::cycle_req_s REQ_I,
   input wire logic REQ_VALID_I,
   input wire logic SUPER_I,
   input wire logic EXC_I,
   input wire logic DONE_I,
   input wire logic [31:0] DATA_I,
   output space_tag_pkg::bus_cycle_s CYCLE_O,
   output logic READY_O,
   output logic REFUSED_O,
   output logic [31:0] INIT_SSP_O,
   output logic [31:0] INIT_PC_O,
   input wire logic [3:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [31:0] REG_RDATA_O
);

   // ==========================================================
   // signals
   space_tag_pkg::seq_state_e state_r;
   space_tag_pkg::seq_state_e state_nxt;
   space_tag_pkg::bus_cycle_s cycle_r;
   space_tag_pkg::bus_cycle_s formed;
   space_tag_pkg::req_kind_e kind_r;
   logic formed_refused;
   logic ready_r;
   logic refused_r;
   logic [31:0] vtb_r;
   logic [31:0] ssp_r;
   logic [31:0] pc_r;
   logic [7:0] ext_vec_r;
   logic [31:0] rdata_r;
   logic take;

   // ==========================================================
   // helpers
   // supervisor or user code for an ordinary access
   function automatic logic [2:0] plain_space(input logic sup, input logic prog);
      logic [2:0] s;
      s = 3'h0;
      if (sup) begin
         s = prog ? space_tag_pkg::SPC_SUPV_PROG : space_tag_pkg::SPC_SUPV_DATA;
      end else begin
         s = prog ? space_tag_pkg::SPC_USER_PROG : space_tag_pkg::SPC_USER_DATA;
      end
      return s;
   endfunction

   // cpu-space address with the type field in place
   function automatic logic [31:0] cpu_addr(input logic [3:0] typ, input logic [15:0] low, input logic ones);
      return {ones ? 12'hfff : 12'h000, typ, low};
   endfunction

   // vector fetch address; wraps at 4 GiB like any other address sum
   function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] num);
      return base + {22'h0, num, 2'b00};
   endfunction

   // ==========================================================
   // cycle forming from a request
   always_comb begin
      formed = '0;
      formed_refused = 1'b0;
      formed.valid = 1'b1;
      formed.write = REQ_I.write;
      case (REQ_I.kind)
         space_tag_pkg::K_DATA: begin
            formed.space = plain_space(SUPER_I | EXC_I, 1'b0); // [R1] [R22] [R23]
            formed.addr = REQ_I.addr;
         end
         space_tag_pkg::K_PROG: begin
            formed.space = plain_space(SUPER_I | EXC_I, 1'b1); // [R22] [R23]
            formed.addr = REQ_I.addr;
         end
         space_tag_pkg::K_ALT: begin
            // privileged: any space, cpu space included, but never the reserved types
            formed.space = REQ_I.alt_space; // [R14] [R13]
            formed.addr = REQ_I.addr;
            if (!SUPER_I) begin
               formed_refused = 1'b1;
            end else if (REQ_I.alt_space == space_tag_pkg::SPC_CPU &&
                         (REQ_I.addr[19:16] == space_tag_pkg::TYPE_MMU_RSVD ||
                          REQ_I.addr[19:16] == space_tag_pkg::TYPE_COPRO_RSVD)) begin
               formed_refused = 1'b1; // [R6]
            end
         end
         space_tag_pkg::K_BREAKPOINT_NUMBER_FIELD: begin
            formed.space = space_tag_pkg::SPC_CPU; // [R21]
            formed.write = 1'b0;
            formed.addr = cpu_addr(space_tag_pkg::TYPE_BREAKPOINT_NUMBER_FIELD, // [R4] [R9]
                                   {11'h000,
                                    REQ_I.breakpoint_number_field_hw ? space_tag_pkg::BREAKPOINT_NUMBER_FIELD_HW_NUM : REQ_I.breakpoint_number_field_num, // [R7]
                                    REQ_I.breakpoint_number_field_hw, 1'b0}, 1'b0); // [R8]
         end
         space_tag_pkg::K_STOP: begin
            // mask write in the bus interface; only a supervisor may halt
            formed.space = space_tag_pkg::SPC_CPU; // [R21]
            formed.write = 1'b1;
            formed.addr = cpu_addr(space_tag_pkg::TYPE_REG, // [R10] [R12]
                                   {MASK_CHIP_SEL, MASK_MODULE_SEL, MASK_REG_HI, REQ_I.level, 1'b0}, 1'b0);
            formed_refused = !SUPER_I;
         end
         space_tag_pkg::K_IACK: begin
            formed.space = space_tag_pkg::SPC_CPU; // [R21]
            formed.write = 1'b0;
            formed.addr = cpu_addr(space_tag_pkg::TYPE_IACK, {12'hfff, REQ_I.level, 1'b1}, 1'b1); // [R15]
         end
         space_tag_pkg::K_VEC: begin
            formed.space = space_tag_pkg::SPC_SUPV_DATA; // [R18] [R23]
            formed.write = 1'b0;
            formed.addr = vec_addr(vtb_r, REQ_I.vec_ext ? ext_vec_r : REQ_I.vec_num); // [R17] [R20]
         end
         default: begin
            formed.valid = 1'b0;
            formed_refused = 1'b1;
         end
      endcase
   end

   assign take = (state_r == space_tag_pkg::ST_IDLE) && REQ_VALID_I;

   // ==========================================================
   // sequencer: two reset fetches, then one cycle at a time
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         space_tag_pkg::ST_RST_SSP: begin
            if (DONE_I) begin
               state_nxt = space_tag_pkg::ST_RST_PC; // [R19]
            end
         end
         space_tag_pkg::ST_RST_PC: begin
            if (DONE_I) begin
               state_nxt = space_tag_pkg::ST_IDLE;
            end
         end
         space_tag_pkg::ST_IDLE: begin
            if (take && !formed_refused) begin
               state_nxt = space_tag_pkg::ST_BUSY;
            end
         end
         space_tag_pkg::ST_BUSY: begin
            if (DONE_I) begin
               state_nxt = space_tag_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = space_tag_pkg::ST_RST_SSP;
         end
      endcase
   end

   // state register
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         state_r <= space_tag_pkg::ST_RST_SSP;
      end else begin
         state_r <= state_nxt;
      end
   end

   // bus cycle outputs; reset starts the stack pointer fetch at once
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         cycle_r.valid <= 1'b1;
         cycle_r.write <= 1'b0;
         cycle_r.space <= space_tag_pkg::SPC_SUPV_PROG; // [R3] [R18]
         cycle_r.addr <= space_tag_pkg::RST_SSP_ADDR;
         kind_r <= space_tag_pkg::K_NONE;
      end else begin
         case (state_r)
            space_tag_pkg::ST_RST_SSP: begin
               if (DONE_I) begin
                  cycle_r.addr <= space_tag_pkg::RST_PC_ADDR; // [R3] [R19]
               end
            end
            space_tag_pkg::ST_IDLE: begin
               if (take && !formed_refused) begin
                  cycle_r <= formed;
                  kind_r <= REQ_I.kind;
               end
            end
            default: begin
               if (DONE_I) begin
                  cycle_r <= '0;
                  kind_r <= space_tag_pkg::K_NONE;
               end
            end
         endcase
      end
   end

   // ready only when idle and no cycle is about to start
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= (state_nxt == space_tag_pkg::ST_IDLE);
      end
   end

   // one-cycle pulse for a request that produces no cycle
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         refused_r <= 1'b0;
      end else begin
         refused_r <= take && formed_refused; // [R6] [R13]
      end
   end

   // reset vector words captured as the fetches complete
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         ssp_r <= 32'h0000_0000;
         pc_r <= 32'h0000_0000;
      end else begin
         if (state_r == space_tag_pkg::ST_RST_SSP && DONE_I) begin
            ssp_r <= DATA_I; // [R19]
         end
         if (state_r == space_tag_pkg::ST_RST_PC && DONE_I) begin
            pc_r <= DATA_I; // [R19]
         end
      end
   end

   // vector number returned by the acknowledging device
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         ext_vec_r <= 8'h00;
      end else if (state_r == space_tag_pkg::ST_BUSY && kind_r == space_tag_pkg::K_IACK && DONE_I) begin
         ext_vec_r <= DATA_I[7:0]; // [R20]
      end
   end

   // ==========================================================
   // register port
   // base is software-owned; any value, so the table may move freely
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         vtb_r <= space_tag_pkg::VTB_RESET;
      end else if (REG_WR_I && REG_ADDR_I == space_tag_pkg::REG_VTB) begin
         vtb_r <= REG_WDATA_I; // [R16]
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         rdata_r <= 32'h0000_0000;
      end else if (REG_RD_I) begin
         case (REG_ADDR_I)
            space_tag_pkg::REG_VTB: rdata_r <= vtb_r;
            space_tag_pkg::REG_STATUS: rdata_r <= {16'h0000, ext_vec_r, 3'h0, kind_r, state_r};
            space_tag_pkg::REG_INIT_SSP: rdata_r <= ssp_r;
            space_tag_pkg::REG_INIT_PC: rdata_r <= pc_r;
            default: rdata_r <= 32'h0000_0000;
         endcase
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   assign CYCLE_O = cycle_r;
   assign READY_O = ready_r;
   assign REFUSED_O = refused_r;
   assign INIT_SSP_O = ssp_r;
   assign INIT_PC_O = pc_r;
   assign REG_RDATA_O = rdata_r;

   // ==========================================================
   // checks
   property p_space_legal;
      @(posedge CLOCK_I) disable iff (RST_I)
      cycle_r.valid && kind_r != space_tag_pkg::K_ALT |->
         cycle_r.space != space_tag_pkg::SPC_RSVD0 && cycle_r.space != space_tag_pkg::SPC_RSVD4 &&
         cycle_r.space != space_tag_pkg::SPC_USER_DEF;
   endproperty
   a_space_legal: assert property (p_space_legal) else $error("reserved space code generated"); // [R2]

   property p_no_rsvd_type;
      @(posedge CLOCK_I) disable iff (RST_I)
      cycle_r.valid && cycle_r.space == space_tag_pkg::SPC_CPU |->
         cycle_r.addr[19:16] != space_tag_pkg::TYPE_MMU_RSVD && cycle_r.addr[19:16] != space_tag_pkg::TYPE_COPRO_RSVD;
   endproperty
   a_no_rsvd_type: assert property (p_no_rsvd_type) else $error("reserved cpu-space type issued"); // [R6]

   property p_breakpoint_number_field_fmt;
      @(posedge CLOCK_I) disable iff (RST_I)
      take && REQ_I.kind == space_tag_pkg::K_BREAKPOINT_NUMBER_FIELD |=>
         cycle_r.space == space_tag_pkg::SPC_CPU && cycle_r.addr[31:5] == 27'h0 && cycle_r.addr[0] == 1'b0 &&
         cycle_r.addr[1] == $past(REQ_I.breakpoint_number_field_hw) &&
         cycle_r.addr[4:2] == ($past(REQ_I.breakpoint_number_field_hw) ? 3'h7 : $past(REQ_I.breakpoint_number_field_num));
   endproperty
   a_breakpoint_number_field_fmt: assert property (p_breakpoint_number_field_fmt) else $error("bad breakpoint acknowledge address"); // [R7]

   property p_iack_fmt;
      @(posedge CLOCK_I) disable iff (RST_I)
      take && REQ_I.kind == space_tag_pkg::K_IACK |=>
         cycle_r.space == space_tag_pkg::SPC_CPU && cycle_r.addr[31:4] == 28'hfffffff &&
         cycle_r.addr[3:1] == $past(REQ_I.level);
   endproperty
   a_iack_fmt: assert property (p_iack_fmt) else $error("bad interrupt acknowledge address"); // [R15]

   property p_stop_fmt;
      @(posedge CLOCK_I) disable iff (RST_I)
      take && REQ_I.kind == space_tag_pkg::K_STOP && SUPER_I |=>
         cycle_r.write && cycle_r.addr[19:16] == 4'h3 && cycle_r.addr[31:20] == 12'h000 &&
         cycle_r.addr[3:1] == $past(REQ_I.level);
   endproperty
   a_stop_fmt: assert property (p_stop_fmt) else $error("bad stop broadcast"); // [R10]

   property p_vec_addr;
      @(posedge CLOCK_I) disable iff (RST_I)
      take && REQ_I.kind == space_tag_pkg::K_VEC && !REQ_I.vec_ext |=>
         cycle_r.space == space_tag_pkg::SPC_SUPV_DATA &&
         cycle_r.addr == $past(vtb_r) + {22'h0, $past(REQ_I.vec_num), 2'b00};
   endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("bad vector fetch address"); // [R17]

   property p_super_code;
      @(posedge CLOCK_I) disable iff (RST_I)
      take && (REQ_I.kind == space_tag_pkg::K_DATA || REQ_I.kind == space_tag_pkg::K_PROG) |=>
         cycle_r.space[2] == $past(SUPER_I | EXC_I);
   endproperty
   a_super_code: assert property (p_super_code) else $error("privilege not reflected in space code"); // [R22]

   property p_reset_pair;
      @(posedge CLOCK_I) disable iff (RST_I)
      state_r == space_tag_pkg::ST_RST_SSP && DONE_I |=>
         state_r == space_tag_pkg::ST_RST_PC && cycle_r.addr == 32'h4 && cycle_r.space == 3'h6 && ssp_r == $past(DATA_I);
   endproperty
   a_reset_pair: assert property (p_reset_pair) else $error("reset fetch sequence broken"); // [R19]

   property p_user_refused;
      @(posedge CLOCK_I) disable iff (RST_I)
      take && REQ_I.kind == space_tag_pkg::K_ALT && !SUPER_I |=> refused_r && !cycle_r.valid;
   endproperty
   a_user_refused: assert property (p_user_refused) else $error("user alternate move not refused"); // [R14]

endmodule

/* File: logic/space_tag_pkg.sv */
// shared constants and types for the bus space tag and vector address block
package space_tag_pkg;

   // ==========================================================
   // address-space codes driven on the space field of the bus cycle
   localparam logic [2:0] SPC_RSVD0 = 3'h0;
   localparam logic [2:0] SPC_USER_DATA = 3'h1;
   localparam logic [2:0] SPC_USER_PROG = 3'h2;
   localparam logic [2:0] SPC_USER_DEF = 3'h3;
   localparam logic [2:0] SPC_RSVD4 = 3'h4;
   localparam logic [2:0] SPC_SUPV_DATA = 3'h5;
   localparam logic [2:0] SPC_SUPV_PROG = 3'h6;
   localparam logic [2:0] SPC_CPU = 3'h7;

   // ==========================================================
   // cpu-space type field on A19..A16
   localparam int TYPE_LSB = 16;
   localparam logic [3:0] TYPE_BREAKPOINT_NUMBER_FIELD = 4'h0;
   localparam logic [3:0] TYPE_MMU_RSVD = 4'h1;
   localparam logic [3:0] TYPE_COPRO_RSVD = 4'h2;
   localparam logic [3:0] TYPE_REG = 4'h3;
   localparam logic [3:0] TYPE_IACK = 4'hf;
   localparam logic [2:0] BREAKPOINT_NUMBER_FIELD_HW_NUM = 3'h7;

   // ==========================================================
   // reset fetch addresses and register map (byte offsets)
   localparam logic [31:0] RST_SSP_ADDR = 32'h0000_0000;
   localparam logic [31:0] RST_PC_ADDR = 32'h0000_0004;
   localparam logic [3:0] REG_VTB = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_INIT_SSP = 4'h8;
   localparam logic [3:0] REG_INIT_PC = 4'hc;
   localparam logic [31:0] VTB_RESET = 32'h0000_0000;

   // ==========================================================
   // request kinds, sequencer states and carriers
   typedef enum logic [2:0] {
      K_DATA = 3'h0, K_PROG = 3'h1, K_ALT = 3'h2, K_BREAKPOINT_NUMBER_FIELD = 3'h3,
      K_STOP = 3'h4, K_IACK = 3'h5, K_VEC = 3'h6, K_NONE = 3'h7
   } req_kind_e;

   typedef enum logic [1:0] {
      ST_RST_SSP = 2'b00, ST_RST_PC = 2'b01, ST_IDLE = 2'b11, ST_BUSY = 2'b10
   } seq_state_e;

   typedef struct packed {
      req_kind_e kind;
      logic write;
      logic [31:0] addr;
      logic [2:0] alt_space;
      logic [2:0] breakpoint_number_field_num;
      logic breakpoint_number_field_hw;
      logic [2:0] level;
      logic [7:0] vec_num;
      logic vec_ext;
   } cycle_req_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [2:0] space;
      logic [31:0] addr;
   } bus_cycle_s;

endpackage

/* File: verif/space_tag_far_end.sv */
// far-side bus responder model for the space tag block
`timescale 1ns/100ps
module space_tag_far_end (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire space_tag_pkg::bus_cycle_s cycle_i,
   input wire logic [3:0] wait_i,
   input wire logic [7:0] iack_vec_i,
   output logic done_o,
   output logic [31:0] data_o,
   output logic [2:0] mask_level_o
);
   localparam logic [31:0] SSP_WORD = 32'h0000_3ffc;
   localparam logic [31:0] PC_WORD = 32'h0000_1000;
   logic [3:0] cnt_r;
   logic is_cpu;
   logic ending;
   // ==========================================================
   // decode
   // cpu-space decoders look at the type field and low bits only, never A31..A20
   assign is_cpu = cycle_i.space == space_tag_pkg::SPC_CPU;
   assign ending = cycle_i.valid && !done_o && cnt_r >= wait_i;
   // ==========================================================
   // completion and read data
   // idle data line toggles every cycle so a stale value never looks valid
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 4'h0;
         done_o <= 1'b0;
         data_o <= 32'h5a5a_a5a5;
      end else if (done_o) begin
         done_o <= 1'b0;
         cnt_r <= 4'h0;
         data_o <= ~data_o;
      end else if (ending) begin
         done_o <= 1'b1;
         cnt_r <= 4'h0;
         if (is_cpu && cycle_i.addr[19:16] == space_tag_pkg::TYPE_IACK) begin
            data_o <= {24'h0, iack_vec_i};
         end else if (cycle_i.space == 3'h6 && cycle_i.addr == 32'h0) begin
            data_o <= SSP_WORD;
         end else if (cycle_i.space == 3'h6 && cycle_i.addr == 32'h4) begin
            data_o <= PC_WORD;
         end else begin
            data_o <= ~data_o;
         end
      end else begin
         cnt_r <= cycle_i.valid ? cnt_r + 4'h1 : 4'h0;
         data_o <= ~data_o;
      end
   end
   // ==========================================================
   // interrupt mask register, written by the stop broadcast
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_level_o <= 3'h0;
      end else if (ending && is_cpu && cycle_i.write && cycle_i.addr[19:16] == space_tag_pkg::TYPE_REG) begin
         mask_level_o <= cycle_i.addr[3:1];
      end
   end
endmodule

/* File: verif/test_space_tag.sv */
// self-checking testbench for the space tag block
`timescale 1ns/100ps
module test_space_tag;
   typedef struct {
      space_tag_pkg::cycle_req_s req;
      logic sup;
      logic exc;
      logic refd;
      logic [2:0] sp;
      logic [31:0] ea;
   } row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   space_tag_pkg::cycle_req_s req = '0;
   logic req_valid = 1'b0;
   logic super_bit = 1'b1;
   logic exc = 1'b0;
   logic done;
   logic [31:0] data;
   space_tag_pkg::bus_cycle_s cycle;
   logic ready;
   logic refused;
   logic [31:0] init_ssp;
   logic [31:0] init_pc;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [3:0] wait_cyc = 4'h0;
   logic [2:0] mask_level;
   logic [31:0] d;
   int errors = 0;
   int total_checks = 0;
   row_s rows[18];
   // ==========================================================
   // clock, design and far side
   always #50 clk = ~clk;
   space_tag i_space_tag (.CLOCK_I(clk), .RST_I(rst), .REQ_I(req), .REQ_VALID_I(req_valid),
      .SUPER_I(super_bit), .EXC_I(exc), .DONE_I(done), .DATA_I(data), .CYCLE_O(cycle),
      .READY_O(ready), .REFUSED_O(refused), .INIT_SSP_O(init_ssp), .INIT_PC_O(init_pc),
      .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
      .REG_RDATA_O(reg_rdata));
   space_tag_far_end i_space_tag_far_end (.clk_i(clk), .rst_i(rst), .cycle_i(cycle), .wait_i(wait_cyc),
      .iack_vec_i(8'h40), .done_o(done), .data_o(data), .mask_level_o(mask_level));
   // ==========================================================
   // helpers
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // bounded wait; a hang is counted and ends the run
   task wait_ready;
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      if (ready !== 1'b1) begin
         errors++;
         test_done();
      end
   endtask
   task reg_write(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task reg_read(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
   endtask
   function automatic row_s mk(space_tag_pkg::req_kind_e k, logic wr, logic [31:0] a, logic [7:0] p,
      logic f, logic sup, logic ex, logic refd, logic [2:0] sp, logic [31:0] ea);
      row_s r;
      r.req = '{kind: k, write: wr, addr: a, alt_space: p[2:0], breakpoint_number_field_num: p[2:0], breakpoint_number_field_hw: f,
         level: p[2:0], vec_num: p, vec_ext: f};
      r.sup = sup;
      r.exc = ex;
      r.refd = refd;
      r.sp = sp;
      r.ea = ea;
      return r;
   endfunction
   // one request, answer checked the cycle after it is taken
   task run_row(input row_s r);
      @(posedge clk);
      req <= r.req;
      super_bit <= r.sup;
      exc <= r.exc;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      check(32'(refused), 32'(r.refd));
      if (!r.refd) begin
         check(32'(cycle.space), 32'(r.sp));
         check(cycle.addr, r.ea);
         if (r.req.kind inside {space_tag_pkg::K_STOP, space_tag_pkg::K_ALT, space_tag_pkg::K_IACK})
            check(32'(cycle.write), 32'(r.req.write));
         if (wait_cyc != 4'h0) begin
            @(negedge clk);
            check(32'(cycle.valid), 32'h1);
         end
      end
      wait_ready;
      check(32'(cycle.valid), 32'h0);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({cycle.valid, cycle.write, cycle.space}, 32'h16);
      check(cycle.addr, 32'h0);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wait_ready;
      check(init_ssp, 32'h0000_3ffc);
      check(init_pc, 32'h0000_1000);
      reg_read(4'h0, d);
      check(d, 32'h0);
      reg_write(4'h0, 32'h0001_0000);
      reg_read(4'h0, d);
      check(d, 32'h0001_0000);
      @(negedge clk);
      check(reg_rdata, 32'h0);
      reg_write(4'h8, 32'h1234_5678);
      reg_read(4'h8, d);
      check(d, 32'h0000_3ffc);
      reg_read(4'h2, d);
      check(d, 32'h0);
      $display("test registers done");
      // table cases: user, supervisor, exception, alternate, refused, cpu-space and vector cycles
      rows[0] = mk(space_tag_pkg::K_DATA, 0, 32'h1234, 0, 0, 0, 0, 0, 3'h1, 32'h1234);
      rows[1] = mk(space_tag_pkg::K_PROG, 0, 32'h2000, 0, 0, 0, 0, 0, 3'h2, 32'h2000);
      rows[2] = mk(space_tag_pkg::K_DATA, 1, 32'h3000, 0, 0, 1, 0, 0, 3'h5, 32'h3000);
      rows[3] = mk(space_tag_pkg::K_PROG, 0, 32'h4000, 0, 0, 1, 0, 0, 3'h6, 32'h4000);
      rows[4] = mk(space_tag_pkg::K_DATA, 0, 32'h1234, 0, 0, 0, 1, 0, 3'h5, 32'h1234);
      rows[5] = mk(space_tag_pkg::K_BREAKPOINT_NUMBER_FIELD, 0, 0, 3, 0, 1, 0, 0, 3'h7, 32'h0000_000c);
      rows[6] = mk(space_tag_pkg::K_BREAKPOINT_NUMBER_FIELD, 0, 0, 2, 1, 1, 0, 0, 3'h7, 32'h0000_001e);
      rows[7] = mk(space_tag_pkg::K_STOP, 1, 0, 5, 0, 1, 0, 0, 3'h7, 32'h0003_000a);
      rows[8] = mk(space_tag_pkg::K_STOP, 1, 0, 5, 0, 0, 0, 1, 3'h0, 32'h0);
      rows[9] = mk(space_tag_pkg::K_ALT, 1, 32'h0003_0104, 3, 0, 1, 0, 0, 3'h3, 32'h0003_0104);
      rows[10] = mk(space_tag_pkg::K_ALT, 0, 32'h5000, 1, 0, 1, 0, 0, 3'h1, 32'h5000);
      rows[11] = mk(space_tag_pkg::K_ALT, 0, 32'h5000, 1, 0, 0, 0, 1, 3'h0, 32'h0);
      rows[12] = mk(space_tag_pkg::K_ALT, 0, 32'h0001_0000, 7, 0, 1, 0, 1, 3'h0, 32'h0);
      rows[13] = mk(space_tag_pkg::K_ALT, 0, 32'h0002_0000, 7, 0, 1, 0, 1, 3'h0, 32'h0);
      rows[14] = mk(space_tag_pkg::K_NONE, 0, 0, 0, 0, 1, 0, 1, 3'h0, 32'h0);
      rows[15] = mk(space_tag_pkg::K_IACK, 0, 0, 5, 0, 1, 0, 0, 3'h7, 32'hffff_fffb);
      rows[16] = mk(space_tag_pkg::K_VEC, 0, 0, 0, 1, 1, 0, 0, 3'h5, 32'h0001_0100);
      rows[17] = mk(space_tag_pkg::K_VEC, 0, 0, 8'hff, 0, 0, 0, 0, 3'h5, 32'h0001_03fc);
      foreach (rows[i]) run_row(rows[i]);
      check(32'(mask_level), 32'h5);
      // status: vector byte from the last acknowledge, no kind, idle
      reg_read(4'h4, d);
      check(d, 32'h0000_401f);
      $display("test table done");
      // slow far side: cycles must stand until completion
      wait_cyc <= 4'h4;
      run_row(rows[15]);
      run_row(rows[7]);
      // base near the top of memory wraps
      reg_write(4'h0, 32'hffff_fff0);
      run_row(mk(space_tag_pkg::K_VEC, 0, 0, 8'h08, 0, 1, 0, 0, 3'h5, 32'h0000_0010));
      $display("test slow and wrap done");
      // reset in the middle of an outstanding cycle
      @(posedge clk);
      req <= rows[0].req;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      @(posedge clk);
      rst <= 1'b1;
      @(negedge clk);
      check({cycle.valid, cycle.write, cycle.space, ready}, 32'h2c);
      check(cycle.addr, 32'h0);
      @(posedge clk);
      rst <= 1'b0;
      wait_ready;
      reg_read(4'h0, d);
      check(d, 32'h0);
      check(init_pc, 32'h0000_1000);
      $display("test mid-run reset done");
      test_done();
   end
endmodule
